// ===== src/serial_irq_logic.sv
// serial_irq_logic.sv: interrupt state, setting and arbitration for two serial ports
// assumes: all inputs synchronous to CLK_I; index 0 is port a, index 1 port b
`timescale 1ns/100ps
`default_nettype none
`include "irq_defines.svh"
module serial_irq_logic (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic CE_I,
	// register port
	input wire logic [`ADDR_W-1:0] ADDR_I,
	input wire logic [`DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [`DATA_W-1:0] RDATA_O,
	// command path
	input wire logic [`NUM_PORTS-1:0] PORT_CMD_STROBE_I,
	input wire logic [`CMD_W-1:0] CMD_DATA_I,
	// line and serializer status, per port
	input wire logic [`NUM_PORTS-1:0] CLEAR_TO_SEND_N_I,
	input wire logic [`NUM_PORTS-1:0] XMIT_BUSY_I,
	input wire logic [`NUM_PORTS-1:0] RECV_BUSY_I,
	input wire logic [`NUM_PORTS-1:0] DATA_SET_READY_N_I,
	input wire logic [`NUM_PORTS-1:0] RING_ACTIVE_I,
	input wire logic [`NUM_PORTS-1:0] REVERSE_CHAN_RECV_I,
	input wire logic [`NUM_PORTS-1:0] CARRIER_DETECT_I,
	// bus side
	input wire logic SYSTEM_CLEAR_N_I,
	input wire logic DAISY_ACK_IN_N_I,
	output logic ATTENTION_REQUEST_N_O,
	output logic DAISY_ACK_OUT_N_O,
	output logic PORT_A_ACK_N_O,
	output logic PORT_B_ACK_N_O
);
	import irq_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// enable step; both bits set toggles, which only matters with disarm
	function automatic logic en_step(input logic cur, input logic b8, input logic b9);
		case ({b9, b8})
			2'h1: en_step = 1'h1;
			2'h2: en_step = 1'h0;
			2'h3: en_step = ~cur;
			default: en_step = cur;
		endcase
	endfunction

	// armed step; never toggles
	function automatic logic arm_step(input logic cur, input logic b8, input logic b9);
		case ({b9, b8})
			2'h0: arm_step = cur;
			2'h3: arm_step = 1'h0;
			default: arm_step = 1'h1;
		endcase
	endfunction

	// pending step: disarm clear first, then set over clear
	function automatic logic pend_step(input logic cur, input logic armed, input logic set,
		input logic clr);
		if (!armed) begin
			pend_step = 1'h0;
		end else if (set) begin
			pend_step = 1'h1;
		end else if (clr) begin
			pend_step = 1'h0;
		end else begin
			pend_step = cur;
		end
	endfunction

	// a level change in either direction
	function automatic logic any_change(input logic rise, input logic fall);
		any_change = rise | fall;
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	localparam int EVW = `EV_W * `NUM_PORTS;

	logic [`NUM_SRC-1:0] en_r;
	logic [`NUM_SRC-1:0] en_nxt;
	logic [`NUM_SRC-1:0] arm_r;
	logic [`NUM_SRC-1:0] arm_nxt;
	logic [`NUM_SRC-1:0] pend_r;
	logic [`NUM_SRC-1:0] pend_nxt;
	logic [`NUM_SRC-1:0] src_req;
	logic [`CMD_W-1:0] cmd_r [`NUM_PORTS];
	logic [`NUM_PORTS-1:0] xmit_ack_r;
	logic [`NUM_PORTS-1:0] xmit_ack_nxt;
	logic [`NUM_PORTS-1:0] hdx_cfg_r;
	logic [`NUM_PORTS-1:0] dir_cfg_r;
	logic [`DATA_W-1:0] rdata_r;
	logic attn_n_r;

	wire sys_clr;
	wire [`NUM_PORTS-1:0] half_duplex_xmit_mode;
	wire [`NUM_PORTS-1:0] port_req;
	wire [`NUM_PORTS-1:0] port_ack;
	wire [EVW-1:0] ev_sig;
	wire [EVW-1:0] ev_rise;
	wire [EVW-1:0] ev_fall;
	wire ack_a_n;
	wire ack_b_n;
	wire ack_out_n;
	route_t route;

	wire wr_cfg;
	wire [`DATA_W-1:0] cfg_word;
	wire [`DATA_W-1:0] stat_word;
	wire [`DATA_W-1:0] rd_mux;

	assign sys_clr = ~SYSTEM_CLEAR_N_I;
	assign port_ack = {~ack_b_n, ~ack_a_n};

	// ----------------------------------------
	// edge detection on all watched levels
	// ----------------------------------------
	edge_watch #(
		.W(EVW)
	) u_edges (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.ce_i(CE_I),
		.sig_i(ev_sig),
		.rise_o(ev_rise),
		.fall_o(ev_fall)
	);

	// ----------------------------------------
	// per port logic
	// ----------------------------------------
	for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
		localparam int RX = p * 2 + `KIND_RX;
		localparam int TX = p * 2 + `KIND_TX;
		localparam int B = p * `EV_W;

		wire cmd_end;
		wire cmd_xmit;
		wire b8;
		wire b9;
		wire upd_rx;
		wire upd_tx;
		wire cmd_xmit_dir_bit_low;
		wire ack_start;
		wire ack_end;
		wire no_recv_request;
		wire xmit_acking;
		wire tx_set;
		wire tx_clr;
		wire rx_set;
		wire rx_clr;
		wire rx_evt;

		// hdx transmit only when half duplex and transmit direction
		assign half_duplex_xmit_mode[p] = hdx_cfg_r[p] & dir_cfg_r[p];

		assign ev_sig[B + `EV_CTS_N] = CLEAR_TO_SEND_N_I[p];
		assign ev_sig[B + `EV_CTS_HDX] = ~CLEAR_TO_SEND_N_I[p] & half_duplex_xmit_mode[p];
		assign ev_sig[B + `EV_XBUSY] = XMIT_BUSY_I[p];
		assign ev_sig[B + `EV_DSR_N] = DATA_SET_READY_N_I[p];
		assign ev_sig[B + `EV_RBUSY] = RECV_BUSY_I[p];
		assign ev_sig[B + `EV_RING] = RING_ACTIVE_I[p];
		assign ev_sig[B + `EV_RCR] = REVERSE_CHAN_RECV_I[p];
		assign ev_sig[B + `EV_DCD] = CARRIER_DETECT_I[p];
		assign ev_sig[B + `EV_STROBE] = PORT_CMD_STROBE_I[p];
		assign ev_sig[B + `EV_ACK] = port_ack[p];

		// command taken at the trailing edge of the strobe
		assign cmd_end = ev_fall[B + `EV_STROBE];
		assign cmd_xmit = cmd_r[p][`CMD_BIT_XMIT];
		assign b8 = cmd_r[p][`CMD_BIT_LO];
		assign b9 = cmd_r[p][`CMD_BIT_HI];
		assign cmd_xmit_dir_bit_low = ~cmd_xmit;
		assign upd_rx = cmd_end & cmd_xmit_dir_bit_low;
		assign upd_tx = cmd_end & cmd_xmit;

		// state bits; system clear overrides any command
		assign en_nxt[RX] = sys_clr ? 1'h0 : (upd_rx ? en_step(en_r[RX], b8, b9) : en_r[RX]);
		assign en_nxt[TX] = sys_clr ? 1'h0 : (upd_tx ? en_step(en_r[TX], b8, b9) : en_r[TX]);
		assign arm_nxt[RX] = sys_clr ? 1'h0 : (upd_rx ? arm_step(arm_r[RX], b8, b9) : arm_r[RX]);
		assign arm_nxt[TX] = sys_clr ? 1'h0 : (upd_tx ? arm_step(arm_r[TX], b8, b9) : arm_r[TX]);

		// a request needs pending, enabled and armed
		assign src_req[RX] = pend_r[RX] & en_r[RX] & arm_r[RX];
		assign src_req[TX] = pend_r[TX] & en_r[TX] & arm_r[TX];
		assign port_req[p] = src_req[RX] | src_req[TX];

		// acknowledge to this port: start and end as seen on the router output
		assign ack_start = ev_rise[B + `EV_ACK];
		assign ack_end = ev_fall[B + `EV_ACK];
		assign no_recv_request = ~src_req[RX];
		assign xmit_acking = port_ack[p] & (ack_start ? no_recv_request : xmit_ack_r[p]);
		assign xmit_ack_nxt[p] = ack_start ? no_recv_request : (ack_end ? 1'h0 : xmit_ack_r[p]);

		// transmit: line drop, cts under hdx transmit, busy fall
		assign tx_set = ev_rise[B + `EV_CTS_N] | ev_rise[B + `EV_CTS_HDX] | ev_fall[B + `EV_XBUSY];
		// cleared only by an acknowledge that served transmit, at its end
		assign tx_clr = ack_end & xmit_ack_r[p];

		// receive: dsr drop, busy fall, ring, and any rcr or dcd change
		assign rx_evt = ev_rise[B + `EV_DSR_N] | ev_fall[B + `EV_RBUSY] | ev_rise[B + `EV_RING] |
			any_change(ev_rise[B + `EV_RCR], ev_fall[B + `EV_RCR]) |
			any_change(ev_rise[B + `EV_DCD], ev_fall[B + `EV_DCD]);
		// held off while a transmit acknowledge runs, so such an event is lost
		assign rx_set = ~xmit_acking & rx_evt;
		// receive request wins the acknowledge; transmit pending untouched
		assign rx_clr = ack_start & src_req[RX] & ~xmit_acking;

		// set beats clear; disarm beats both
		assign pend_nxt[TX] = sys_clr ? 1'h0 : pend_step(pend_r[TX], arm_r[TX], tx_set, tx_clr);
		assign pend_nxt[RX] = sys_clr ? 1'h0 : pend_step(pend_r[RX], arm_r[RX], rx_set, rx_clr);

		// command word caught on the leading edge of the strobe
		always_ff @(posedge CLK_I) begin
			if (!RSTN_I) begin
				cmd_r[p] <= '0;
			end else if (CE_I && ev_rise[B + `EV_STROBE]) begin
				cmd_r[p] <= CMD_DATA_I;
			end
		end
	end

	// ----------------------------------------
	// acknowledge arbitration
	// ----------------------------------------

	// host drives the chain in answer to attention; board only follows it
	ack_router u_router (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.ce_i(CE_I),
		.ack_i(~DAISY_ACK_IN_N_I),
		.req_a_i(port_req[0]),
		.req_b_i(port_req[1]),
		.ack_a_n_o(ack_a_n),
		.ack_b_n_o(ack_b_n),
		.ack_out_n_o(ack_out_n),
		.route_o(route)
	);

	assign PORT_A_ACK_N_O = ack_a_n;
	assign PORT_B_ACK_N_O = ack_b_n;
	assign DAISY_ACK_OUT_N_O = ack_out_n;

	// ----------------------------------------
	// register port
	// ----------------------------------------
	assign wr_cfg = WR_I & (ADDR_I == `ADDR_CFG);
	// field positions kept in the defines header; spare bits read zero
	assign cfg_word[`CFG_HDX_LSB +: `NUM_PORTS] = hdx_cfg_r;
	assign cfg_word[`CFG_DIR_LSB +: `NUM_PORTS] = dir_cfg_r;
	assign cfg_word[`DATA_W-1:`CFG_USED] = '0;
	assign stat_word[`STAT_EN_LSB +: `NUM_SRC] = en_r;
	assign stat_word[`STAT_ARM_LSB +: `NUM_SRC] = arm_r;
	assign stat_word[`STAT_PEND_LSB +: `NUM_SRC] = pend_r;
	assign stat_word[`STAT_REQ_LSB +: `NUM_PORTS] = port_req;
	assign stat_word[`STAT_ROUTE_LSB +: $bits(route_t)] = route;
	// unmapped addresses read zero
	assign rd_mux = (ADDR_I == `ADDR_CFG) ? cfg_word :
		((ADDR_I == `ADDR_STAT) ? stat_word : '0);

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			en_r <= '0;
			arm_r <= '0;
		end else if (CE_I) begin
			en_r <= en_nxt;
			arm_r <= arm_nxt;
		end
	end

	// pending bits and the transmit acknowledge marks
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			pend_r <= '0;
			xmit_ack_r <= '0;
		end else if (CE_I) begin
			pend_r <= pend_nxt;
			xmit_ack_r <= xmit_ack_nxt;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			hdx_cfg_r <= '0;
			dir_cfg_r <= '0;
		end else if (CE_I && wr_cfg) begin
			hdx_cfg_r <= WDATA_I[`CFG_HDX_LSB +: `NUM_PORTS];
			dir_cfg_r <= WDATA_I[`CFG_DIR_LSB +: `NUM_PORTS];
		end
	end

	// read data only in the cycle after the strobe
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			rdata_r <= '0;
		end else if (CE_I) begin
			rdata_r <= RD_I ? rd_mux : '0;
		end
	end

	// registered so the bus sees no decode glitches
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			attn_n_r <= 1'h1;
		end else if (CE_I) begin
			attn_n_r <= ~(|port_req);
		end
	end

	assign RDATA_O = rdata_r;
	assign ATTENTION_REQUEST_N_O = attn_n_r;
endmodule
`default_nettype wire

// ===== src/irq_defines.svh
// irq_defines.svh: offsets, field positions and event indices
// assumes: included by bare name from serial_irq_logic and ack_router; edge_watch does not include it
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// ----------------------------------------
// command word fields
// ----------------------------------------
`define CMD_W 16
`define CMD_BIT_LO 8
`define CMD_BIT_HI 9
`define CMD_BIT_XMIT 15

// ----------------------------------------
// source numbering: port * 2 + kind
// ----------------------------------------
`define NUM_PORTS 2
`define NUM_SRC 4
`define KIND_RX 0
`define KIND_TX 1

// ----------------------------------------
// watched signal indices, per port
// ----------------------------------------
`define EV_CTS_N 0
`define EV_CTS_HDX 1
`define EV_XBUSY 2
`define EV_DSR_N 3
`define EV_RBUSY 4
`define EV_RING 5
`define EV_RCR 6
`define EV_DCD 7
`define EV_STROBE 8
`define EV_ACK 9
`define EV_W 10

// ----------------------------------------
// register port
// ----------------------------------------
`define ADDR_W 4
`define DATA_W 16
`define ADDR_CFG 4'h0
`define ADDR_STAT 4'h1
`define CFG_HDX_LSB 0
`define CFG_DIR_LSB 2
`define CFG_USED 4
`define STAT_EN_LSB 0
`define STAT_ARM_LSB 4
`define STAT_PEND_LSB 8
`define STAT_REQ_LSB 12
`define STAT_ROUTE_LSB 14

`endif

// ===== src/irq_pkg.sv
// irq_pkg.sv: shared types of the interrupt logic
// assumes: compiled before every module of the block
package irq_pkg;
	// acknowledge routing, held for a whole incoming acknowledge
	typedef enum logic [1:0] {
		ROUTE_IDLE,
		ROUTE_A,
		ROUTE_B,
		ROUTE_CHAIN
	} route_t;
endpackage

// ===== src/edge_watch.sv
// edge_watch.sv: rise and fall detection on a bundle of levels
// assumes: inputs synchronous to clk; single clock domain
`timescale 1ns/100ps
`default_nettype none
module edge_watch #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [W-1:0] sig_i,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);
	logic [W-1:0] prev_r;
	logic primed_r;

	// no edges in the first enabled cycle after reset: prev_r holds no history yet
	assign rise_o = primed_r ? (sig_i & ~prev_r) : '0;
	assign fall_o = primed_r ? (~sig_i & prev_r) : '0;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			prev_r <= '0;
			primed_r <= 1'h0;
		end else if (ce_i) begin
			prev_r <= sig_i;
			primed_r <= 1'h1;
		end
	end
endmodule
`default_nettype wire

// ===== src/ack_router.sv
// ack_router.sv: routes the chained acknowledge to port a, port b or onward
// assumes: ack_i active high and synchronous; outputs active low, registered
`timescale 1ns/100ps
`default_nettype none
`include "irq_defines.svh"
module ack_router (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic ack_i,
	input wire logic req_a_i,
	input wire logic req_b_i,
	output logic ack_a_n_o,
	output logic ack_b_n_o,
	output logic ack_out_n_o,
	output irq_pkg::route_t route_o
);
	import irq_pkg::*;

	route_t route_r;
	route_t pick;
	route_t route_nxt;

	// port a wins over port b, otherwise pass down the chain
	assign pick = req_a_i ? ROUTE_A : (req_b_i ? ROUTE_B : ROUTE_CHAIN);
	// choice made once per pulse; a later request waits for the next pulse
	assign route_nxt = !ack_i ? ROUTE_IDLE : ((route_r == ROUTE_IDLE) ? pick : route_r);
	assign route_o = route_r;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			route_r <= ROUTE_IDLE;
			ack_a_n_o <= 1'h1;
			ack_b_n_o <= 1'h1;
			ack_out_n_o <= 1'h1;
		end else if (ce_i) begin
			route_r <= route_nxt;
			ack_a_n_o <= (route_nxt != ROUTE_A);
			ack_b_n_o <= (route_nxt != ROUTE_B);
			ack_out_n_o <= (route_nxt != ROUTE_CHAIN);
		end
	end
endmodule
`default_nettype wire

// ===== test/irq_checker.sv
// irq_checker.sv: port-level assertions on the interrupt logic
// assumes: bound to serial_irq_logic; CE_I dropped only while the bus is idle
`timescale 1ns/100ps
`default_nettype none
`include "irq_defines.svh"
module irq_checker (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic RD_I,
	input wire logic [`ADDR_W-1:0] ADDR_I,
	input wire logic [`DATA_W-1:0] RDATA_O,
	input wire logic SYSTEM_CLEAR_N_I,
	input wire logic DAISY_ACK_IN_N_I,
	input wire logic ATTENTION_REQUEST_N_O,
	input wire logic DAISY_ACK_OUT_N_O,
	input wire logic PORT_A_ACK_N_O,
	input wire logic PORT_B_ACK_N_O
);
	wire logic [2:0] acks_n = {PORT_A_ACK_N_O, PORT_B_ACK_N_O, DAISY_ACK_OUT_N_O};
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	// ----
	// acknowledge routing
	// ----
	one_route_a: assert property ($onehot0(~acks_n)) else $error("two acknowledge outputs low");
	ack_answer_a: assert property ($fell(DAISY_ACK_IN_N_I) |=> !(&acks_n))
		else $error("incoming acknowledge not routed");
	route_frozen_a: assert property (!DAISY_ACK_IN_N_I ##1 !DAISY_ACK_IN_N_I |=> $stable(acks_n))
		else $error("routing moved during acknowledge");
	ack_idle_a: assert property (DAISY_ACK_IN_N_I |=> &acks_n)
		else $error("acknowledge output without incoming");
	chain_pass_a: assert property ($fell(DAISY_ACK_IN_N_I) |=> DAISY_ACK_OUT_N_O == !ATTENTION_REQUEST_N_O)
		else $error("chain pass does not match request state");
	// ----
	// clear and register port
	// ----
	clear_quiet_a: assert property (!SYSTEM_CLEAR_N_I |=> ##1 ATTENTION_REQUEST_N_O)
		else $error("attention after system clear");
	read_idle_a: assert property (!RD_I |=> RDATA_O == 16'h0000) else $error("read data outside read");
	unmapped_rd_a: assert property (RD_I && ADDR_I > 4'h1 |=> RDATA_O == 16'h0000)
		else $error("unmapped read not zero");
endmodule
bind serial_irq_logic irq_checker i_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .RD_I(RD_I), .ADDR_I(ADDR_I),
	.RDATA_O(RDATA_O), .SYSTEM_CLEAR_N_I(SYSTEM_CLEAR_N_I), .DAISY_ACK_IN_N_I(DAISY_ACK_IN_N_I),
	.ATTENTION_REQUEST_N_O(ATTENTION_REQUEST_N_O), .DAISY_ACK_OUT_N_O(DAISY_ACK_OUT_N_O),
	.PORT_A_ACK_N_O(PORT_A_ACK_N_O), .PORT_B_ACK_N_O(PORT_B_ACK_N_O));
`default_nettype wire

// ===== test/host_chain_model.sv
// host_chain_model.sv: host acknowledge source and the next board down
// assumes: one clock shared with the design; active-low chain lines
`timescale 1ns/100ps
`default_nettype none
module host_chain_model #(
	parameter int HOLD = 3,
	parameter int GAP = 2
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic answer_i,
	input wire logic solo_i,
	input wire logic attn_n_i,
	input wire logic ack_out_n_i,
	output logic ack_in_n_o,
	output logic [7:0] passed_o
);
	logic [3:0] cnt_r;
	logic prev_r;
	always_ff @(posedge clk_i) begin
		prev_r <= ack_out_n_i;
		if (!rstn_i) begin
			cnt_r <= 4'h0;
			ack_in_n_o <= 1'b1;
			passed_o <= 8'h00;
		end else begin
			// next board takes every acknowledge passed on
			if (prev_r && !ack_out_n_i) passed_o <= passed_o + 8'h01;
			if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
				if (cnt_r == 4'(GAP + 1)) ack_in_n_o <= 1'b1;
			end else if (answer_i && (!attn_n_i || solo_i)) begin
				// gated by answer_i so a test can hold requests pending
				ack_in_n_o <= 1'b0;
				cnt_r <= 4'(HOLD + GAP);
			end
		end
	end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// testbench.sv: directed tests of the interrupt logic
// assumes: host_chain_model and irq_checker compiled before
`timescale 1ns/100ps
`default_nettype none
`include "irq_defines.svh"
module testbench;
	logic clk, rstn, wr, rd, system_clear_n_n, answer, solo, seen_clr, ce;
	logic [`ADDR_W-1:0] addr;
	logic [`DATA_W-1:0] wdata, rdata;
	logic [`CMD_W-1:0] cmd;
	logic [1:0] strobe, cts_n, xbusy, rbusy, dsr_n, ring, rcr, dcd, seen;
	logic attn_n, ack_in_n, ack_out_n, ack_a_n, ack_b_n;
	logic [7:0] passed;
	logic [1:0] codes [5] = '{2'd1, 2'd0, 2'd2, 2'd3, 2'd1};
	logic [15:0] exps [5] = '{16'h0022, 16'h0022, 16'h0020, 16'h0000, 16'h0022};
	localparam logic [15:0] PEND_M = 16'h0F00;
	int err_count = 0;
	int check_count = 0;
	serial_irq_logic i_dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PORT_CMD_STROBE_I(strobe), .CMD_DATA_I(cmd),
		.CLEAR_TO_SEND_N_I(cts_n), .XMIT_BUSY_I(xbusy), .RECV_BUSY_I(rbusy), .DATA_SET_READY_N_I(dsr_n),
		.RING_ACTIVE_I(ring), .REVERSE_CHAN_RECV_I(rcr), .CARRIER_DETECT_I(dcd), .SYSTEM_CLEAR_N_I(system_clear_n_n),
		.DAISY_ACK_IN_N_I(ack_in_n), .ATTENTION_REQUEST_N_O(attn_n), .DAISY_ACK_OUT_N_O(ack_out_n),
		.PORT_A_ACK_N_O(ack_a_n), .PORT_B_ACK_N_O(ack_b_n));
	host_chain_model i_host (.clk_i(clk), .rstn_i(rstn), .answer_i(answer), .solo_i(solo), .attn_n_i(attn_n),
		.ack_out_n_i(ack_out_n), .ack_in_n_o(ack_in_n), .passed_o(passed));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// sticky record of which port got an acknowledge; only this process writes it
	always @(posedge clk) begin
		if (seen_clr) begin
			seen <= 2'h0;
		end else begin
			if (!ack_a_n) seen[1] <= 1'b1;
			if (!ack_b_n) seen[0] <= 1'b1;
		end
	end
	// ----
	// access tasks
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata & m, exp);
	endtask
	task automatic send(input int p, input logic [15:0] d);
		@(posedge clk);
		strobe[p] <= 1'b1;
		cmd <= d;
		@(posedge clk);
		strobe[p] <= 1'b0;
		idle(2);
	endtask
	task automatic ack1();
		@(posedge clk) {answer, seen_clr} <= 2'h3;
		@(posedge clk) {answer, seen_clr} <= 2'h0;
		idle(10);
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----
	// tests
	// ----
	initial begin
		{rstn, wr, rd, answer, solo, seen_clr} = '0;
		{addr, wdata, cmd, strobe, xbusy, dsr_n, ring, rcr, dcd} = '0;
		{cts_n, rbusy, system_clear_n_n, ce} = 6'h3F;
		idle(12);
		rstn <= 1'b1;
		idle(2);
		rd_reg(4'h1, 16'hFFFF, 16'h0000);
		wr_reg(4'h1, 16'hFFFF);
		rd_reg(4'h1, 16'hFFFF, 16'h0000);
		rd_reg(4'h7, 16'hFFFF, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			send(0, {6'h20, codes[i], 8'h00});
			rd_reg(4'h1, (i == 3) ? 16'hFFFD : 16'hFFFF, exps[i]);
		end
		send(0, 16'h0100);
		rd_reg(4'h1, 16'hFFFF, 16'h0033);
		// events on disarmed port b must leave nothing pending
		@(posedge clk) xbusy <= 2'b10;
		@(posedge clk) {xbusy, ring} <= 4'b0010;
		idle(3);
		rd_reg(4'h1, PEND_M, 16'h0000);
		chk(attn_n, 16'h1);
		send(1, 16'h8100);
		send(1, 16'h0100);
		rd_reg(4'h1, 16'h00FF, 16'h00FF);
		// transmit request on port a, answered once
		@(posedge clk) xbusy <= 2'b01;
		@(posedge clk) xbusy <= 2'b00;
		idle(4);
		rd_reg(4'h1, PEND_M, 16'h0200);
		chk(attn_n, 16'h0);
		idle(6);
		rd_reg(4'h1, PEND_M, 16'h0200);
		ack1();
		chk(seen, 16'h2);
		rd_reg(4'h1, PEND_M, 16'h0000);
		// receive and transmit together: receive served first
		@(posedge clk) xbusy <= 2'b01;
		@(posedge clk) {xbusy, dcd} <= 4'b0001;
		idle(4);
		rd_reg(4'h1, PEND_M, 16'h0300);
		ack1();
		rd_reg(4'h1, PEND_M, 16'h0200);
		// receive event inside the transmit acknowledge is dropped
		@(posedge clk) answer <= 1'b1;
		@(posedge clk) answer <= 1'b0;
		idle(1);
		@(posedge clk) dcd <= 2'b00;
		idle(10);
		rd_reg(4'h1, PEND_M, 16'h0000);
		// port b acknowledged; port a request arrives mid-pulse
		@(posedge clk) xbusy <= 2'b10;
		@(posedge clk) xbusy <= 2'b00;
		idle(4);
		@(posedge clk) {answer, seen_clr} <= 2'h3;
		@(posedge clk) {answer, seen_clr, dcd} <= 4'h1;
		idle(10);
		chk(seen, 16'h1);
		ack1();
		chk(seen, 16'h2);
		// nothing pending: acknowledge goes down the chain
		@(posedge clk) {answer, solo} <= 2'b11;
		@(posedge clk) {answer, solo} <= 2'b00;
		idle(10);
		chk(passed, 16'h1);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk) case (i)
				0: dsr_n <= 2'b01;
				1: rbusy <= 2'b10;
				2: ring <= 2'b11;
				3: rcr <= 2'b01;
				default: dcd <= 2'b00;
			endcase
			idle(3);
			rd_reg(4'h1, PEND_M, 16'h0100);
			ack1();
		end
		// half duplex alone is not transmit mode
		@(posedge clk) cts_n <= 2'b10;
		wr_reg(4'h0, 16'h0001);
		idle(3);
		rd_reg(4'h1, PEND_M, 16'h0000);
		wr_reg(4'h0, 16'h0005);
		idle(3);
		rd_reg(4'h1, PEND_M, 16'h0200);
		// frozen clock enable: a whole disarm command goes unseen
		@(posedge clk) ce <= 1'b0;
		send(1, 16'h8300);
		@(posedge clk) ce <= 1'b1;
		idle(1);
		rd_reg(4'h1, 16'h00FF, 16'h00FF);
		@(posedge clk) system_clear_n_n <= 1'b0;
		@(posedge clk) system_clear_n_n <= 1'b1;
		rd_reg(4'h1, 16'h0FFF, 16'h0000);
		chk(attn_n, 16'h1);
		rd_reg(4'h0, 16'hFFFF, 16'h0005);
		wrap_up();
	end
	// cuts a hang short; tests need well under 2000 cycles
	initial begin
		repeat (4000) @(posedge clk);
		err_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
